// ===== rtl/sfc_feature_ctrl.sv
// Summary of operation
// R1 - Host gives function, feature, state, flags
// R2 - Flag bit 0 persists; hard reset restores
// R3 - Get state: low byte count, high number
// R4 - Get flags: low byte count, high number
// R5 - Success gives error 00h, status 50h
// R6 - Feature 1: by set-features, on, off
// R7 - Forced cache state overrides set-features
// R8 - Set-features accepted but ignored when forced
// R9 - Identify word 85 bit 5 shows cache
// R10 - Cache policy defaults to set-features
// R11 - Feature 2 reordering, enabled by default
// R12 - Disable reordering accepted, silently ignored
// R13 - Feature 3 interval, zero invalid
// R14 - Interval set resets queue, index zero
// R15 - Other queue locations filled with 80h
// R16 - Sampling period and limits untouched
// R17 - Logging interval defaults to one minute
// R18 - Unknown function or feature is aborted
//
// Decided for this implementation: the APB slave port and the placing of the registers.
module sfc_feature_ctrl
    import sfc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hard_reset,
    input wire logic [7:0] cur_temp,
    input wire logic log_wr,
    input wire logic [7:0] log_temp,
    output logic wc_enable,
    output logic id_w85_wc,
    output logic reorder_en,
    output logic [15:0] log_interval,
    output logic [6:0] queue_index,
    output logic queue_busy
);
    typedef enum logic [0:0] {S_IDLE, S_FILL} sfc_fill_e;

    function automatic logic feat_known(input logic [15:0] f);
        feat_known = (f == SFC_FT_WCACHE) || (f == SFC_FT_REORDER) || (f == SFC_FT_INTERVAL);
    endfunction : feat_known

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a[1:0] == 2'b00) && (a <= SFC_OFF_QDATA);
    endfunction : addr_known

    logic [15:0] func_reg, feat_reg, state_reg, opt_reg;
    logic [7:0] res_err_reg, res_stat_reg, res_sc_reg, res_sn_reg;
    logic [15:0] wc_pol_reg, wc_pol_nv_reg, int_reg, int_nv_reg;
    logic wc_flag_reg, int_flag_reg, ro_flag_reg;
    logic [6:0] qidx_reg, fill_cnt_reg, qaddr_reg;
    sfc_fill_e fsm_reg;
    logic apb_wr, apb_setup, go, start_fill, sf_req, sf_wc;
    logic cmd_ok, do_wc, do_int, do_ro;
    logic [15:0] ret_word;
    logic ret_valid;
    logic mem_we;
    logic [6:0] mem_waddr;
    logic [7:0] mem_wdata, mem_rdata;
    logic [31:0] rd_mux;

    assign apb_wr = psel && penable && pwrite;
    assign apb_setup = psel && !penable;
    // Commands arriving mid-fill are dropped; software polls the busy bit
    assign go = apb_wr && (paddr == SFC_OFF_GO) && pwdata[SFC_GO_BIT] && (fsm_reg == S_IDLE);
    assign sf_req = apb_wr && (paddr == SFC_OFF_SETFEAT);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_known(paddr);

    // R1 command words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_reg <= 16'h0000;
            feat_reg <= 16'h0000;
            state_reg <= 16'h0000;
            opt_reg <= 16'h0000;
            qaddr_reg <= 7'h00;
        end else if (apb_wr) begin
            case (paddr)
                SFC_OFF_FUNC: func_reg <= pwdata[15:0];
                SFC_OFF_FEAT: feat_reg <= pwdata[15:0];
                SFC_OFF_STATE: state_reg <= pwdata[15:0];
                SFC_OFF_OPT: opt_reg <= pwdata[15:0];
                SFC_OFF_QADDR: qaddr_reg <= pwdata[6:0];
                default: ;
            endcase
        end
    end

    // R18 decode and abort
    always_comb begin
        cmd_ok = 1'b0;
        do_wc = 1'b0;
        do_int = 1'b0;
        do_ro = 1'b0;
        ret_word = 16'h0000;
        ret_valid = 1'b0;
        case (func_reg)
            SFC_FN_SET: begin
                case (feat_reg)
                    // R6 cache policy states
                    SFC_FT_WCACHE: begin
                        cmd_ok = (state_reg == SFC_WC_BY_SF) || (state_reg == SFC_WC_FORCE_ON)
                            || (state_reg == SFC_WC_FORCE_OFF);
                        do_wc = cmd_ok;
                    end
                    // R11 reordering states
                    SFC_FT_REORDER: begin
                        cmd_ok = (state_reg == SFC_RO_EN) || (state_reg == SFC_RO_DIS);
                        do_ro = cmd_ok;
                    end
                    // R13 zero interval invalid
                    SFC_FT_INTERVAL: begin
                        cmd_ok = (state_reg != SFC_INTERVAL_BAD);
                        do_int = cmd_ok;
                    end
                    default: cmd_ok = 1'b0;
                endcase
            end
            SFC_FN_GET: begin
                cmd_ok = feat_known(feat_reg);
                ret_valid = cmd_ok;
                case (feat_reg)
                    SFC_FT_WCACHE: ret_word = wc_pol_reg;
                    // R12 always reports enabled
                    SFC_FT_REORDER: ret_word = SFC_RO_EN;
                    SFC_FT_INTERVAL: ret_word = int_reg;
                    default: ret_word = 16'h0000;
                endcase
            end
            SFC_FN_FLAGS: begin
                cmd_ok = feat_known(feat_reg);
                ret_valid = cmd_ok;
                case (feat_reg)
                    SFC_FT_WCACHE: ret_word = {15'h0000, wc_flag_reg};
                    SFC_FT_REORDER: ret_word = {15'h0000, ro_flag_reg};
                    SFC_FT_INTERVAL: ret_word = {15'h0000, int_flag_reg};
                    default: ret_word = 16'h0000;
                endcase
            end
            default: cmd_ok = 1'b0;
        endcase
    end

    // R3 R4 R5 task-file answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_err_reg <= SFC_ERR_OK;
            res_stat_reg <= SFC_STAT_OK;
            res_sc_reg <= 8'h00;
            res_sn_reg <= 8'h00;
        end else if (go) begin
            res_err_reg <= cmd_ok ? SFC_ERR_OK : SFC_ERR_ABORT;
            res_stat_reg <= cmd_ok ? SFC_STAT_OK : SFC_STAT_ERR;
            res_sc_reg <= ret_valid ? ret_word[7:0] : 8'h00;
            res_sn_reg <= ret_valid ? ret_word[15:8] : 8'h00;
        end
    end

    // R2 R10 cache policy, volatile or kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wc_pol_reg <= SFC_WC_RST;
            wc_pol_nv_reg <= SFC_WC_RST;
            wc_flag_reg <= 1'b0;
        end else if (go && do_wc) begin
            wc_pol_reg <= state_reg;
            wc_flag_reg <= opt_reg[SFC_PERSIST_BIT];
            if (opt_reg[SFC_PERSIST_BIT]) begin
                wc_pol_nv_reg <= state_reg;
            end
        end else if (hard_reset) begin
            wc_pol_reg <= wc_pol_nv_reg;
        end
    end

    // R2 R17 logging interval, volatile or kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_reg <= SFC_INTERVAL_RST;
            int_nv_reg <= SFC_INTERVAL_RST;
            int_flag_reg <= 1'b0;
        end else if (go && do_int) begin
            int_reg <= state_reg;
            int_flag_reg <= opt_reg[SFC_PERSIST_BIT];
            if (opt_reg[SFC_PERSIST_BIT]) begin
                int_nv_reg <= state_reg;
            end
        end else if (hard_reset) begin
            int_reg <= int_nv_reg;
        end
    end

    // R12 only the flag is kept, reordering stays on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ro_flag_reg <= 1'b0;
        end else if (go && do_ro) begin
            ro_flag_reg <= opt_reg[SFC_PERSIST_BIT];
        end
    end

    assign start_fill = go && do_int;

    // R14 R16 queue reset touches only queue and index
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fsm_reg <= S_IDLE;
            fill_cnt_reg <= 7'h00;
            qidx_reg <= 7'h00;
        end else begin
            case (fsm_reg)
                S_IDLE: begin
                    if (start_fill) begin
                        fsm_reg <= S_FILL;
                        fill_cnt_reg <= 7'h01;
                        qidx_reg <= 7'h00;
                    end else if (log_wr) begin
                        qidx_reg <= qidx_reg + 7'h01;
                    end
                end
                S_FILL: begin
                    fill_cnt_reg <= fill_cnt_reg + 7'h01;
                    if (fill_cnt_reg == SFC_QLAST) begin
                        fsm_reg <= S_IDLE;
                    end
                end
                default: fsm_reg <= S_IDLE;
            endcase
        end
    end

    // R15 marker fill, one location a cycle
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = qidx_reg + 7'h01;
        mem_wdata = log_temp;
        if (fsm_reg == S_FILL) begin
            mem_we = 1'b1;
            mem_waddr = fill_cnt_reg;
            mem_wdata = SFC_QMARK;
        end else if (start_fill) begin
            mem_we = 1'b1;
            mem_waddr = 7'h00;
            mem_wdata = cur_temp;
        end else if (log_wr) begin
            mem_we = 1'b1;
        end
    end

    sfc_hist_mem u_mem (
        .pclk(pclk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(qaddr_reg),
        .rdata(mem_rdata)
    );

    sfc_wc_policy u_wc (
        .pclk(pclk),
        .presetn(presetn),
        .policy(wc_pol_reg),
        .sf_req(sf_req),
        .sf_val(pwdata[SFC_SF_WC_BIT]),
        .wc_on(wc_enable),
        .sf_wc(sf_wc)
    );

    // R9 identify bit follows real state
    assign id_w85_wc = wc_enable;
    assign reorder_en = 1'b1;
    assign log_interval = int_reg;
    assign queue_index = qidx_reg;
    assign queue_busy = (fsm_reg == S_FILL);

    always_comb begin
        case (paddr)
            SFC_OFF_FUNC: rd_mux = {16'h0000, func_reg};
            SFC_OFF_FEAT: rd_mux = {16'h0000, feat_reg};
            SFC_OFF_STATE: rd_mux = {16'h0000, state_reg};
            SFC_OFF_OPT: rd_mux = {16'h0000, opt_reg};
            SFC_OFF_RESULT: rd_mux = {res_sn_reg, res_sc_reg, res_stat_reg, res_err_reg};
            SFC_OFF_WCSTAT: begin
                rd_mux = {16'h0000, wc_pol_reg};
                rd_mux[SFC_WCSTAT_ACT_BIT] = wc_enable;
                rd_mux[SFC_WCSTAT_SF_BIT] = sf_wc;
                rd_mux[SFC_WCSTAT_RO_BIT] = reorder_en;
                rd_mux[SFC_WCSTAT_BUSY_BIT] = queue_busy;
            end
            SFC_OFF_INTERVAL: rd_mux = {16'h0000, int_reg};
            SFC_OFF_SETFEAT: rd_mux = {31'h0000_0000, sf_wc};
            SFC_OFF_QADDR: rd_mux = {25'h000_0000, qaddr_reg};
            SFC_OFF_QDATA: rd_mux = {24'h00_0000, mem_rdata};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Sampled in setup so access phase has no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    property p_get_wc;
        @(posedge pclk) disable iff (!presetn)
        go && func_reg == SFC_FN_GET && feat_reg == SFC_FT_WCACHE
            |=> res_sc_reg == $past(wc_pol_reg[7:0]) && res_sn_reg == $past(wc_pol_reg[15:8]);
    endproperty
    a_get_wc: assert property (p_get_wc) else $error("get state bytes wrong"); // R3

    property p_flags;
        @(posedge pclk) disable iff (!presetn)
        go && func_reg == SFC_FN_FLAGS && feat_reg == SFC_FT_INTERVAL
            |=> res_sc_reg == {7'h00, $past(int_flag_reg)} && res_sn_reg == 8'h00;
    endproperty
    a_flags: assert property (p_flags) else $error("option flag bytes wrong"); // R4

    property p_ok;
        @(posedge pclk) disable iff (!presetn)
        go && cmd_ok |=> res_err_reg == SFC_ERR_OK && res_stat_reg == SFC_STAT_OK;
    endproperty
    a_ok: assert property (p_ok) else $error("success answer wrong"); // R5

    property p_abort;
        @(posedge pclk) disable iff (!presetn)
        go && !feat_known(feat_reg)
            |=> res_err_reg == SFC_ERR_ABORT && res_stat_reg == SFC_STAT_ERR;
    endproperty
    a_abort: assert property (p_abort) else $error("unknown feature not aborted"); // R18

    property p_forced;
        @(posedge pclk) disable iff (!presetn)
        (wc_pol_reg == SFC_WC_FORCE_OFF) [*2] |-> !wc_enable && !id_w85_wc;
    endproperty
    a_forced: assert property (p_forced) else $error("cache not held off"); // R7

    property p_int_zero;
        @(posedge pclk) disable iff (!presetn)
        go && func_reg == SFC_FN_SET && feat_reg == SFC_FT_INTERVAL && state_reg == 16'h0000
            |=> int_reg == $past(int_reg) && !queue_busy;
    endproperty
    a_int_zero: assert property (p_int_zero) else $error("zero interval taken"); // R13

    property p_fill_start;
        @(posedge pclk) disable iff (!presetn)
        start_fill |-> mem_we && mem_waddr == 7'h00 && mem_wdata == cur_temp
            ##1 queue_index == 7'h00 && queue_busy;
    endproperty
    a_fill_start: assert property (p_fill_start) else $error("queue reset start wrong"); // R14

    property p_fill_len;
        @(posedge pclk) disable iff (!presetn)
        start_fill |-> ##127 (queue_busy && mem_wdata == SFC_QMARK) ##1 !queue_busy;
    endproperty
    a_fill_len: assert property (p_fill_len) else $error("marker fill length wrong"); // R15

    property p_volatile;
        @(posedge pclk) disable iff (!presetn)
        hard_reset && !go |=> wc_pol_reg == $past(wc_pol_nv_reg) && int_reg == $past(int_nv_reg);
    endproperty
    a_volatile: assert property (p_volatile) else $error("hard reset restore wrong"); // R2

    c_fill: cover property (@(posedge pclk) disable iff (!presetn) start_fill ##128 !queue_busy);
    c_force: cover property (@(posedge pclk) disable iff (!presetn)
        go && do_wc && state_reg == SFC_WC_FORCE_ON);
    c_abort: cover property (@(posedge pclk) disable iff (!presetn) go && !cmd_ok);
    c_hard: cover property (@(posedge pclk) disable iff (!presetn) hard_reset);
endmodule : sfc_feature_ctrl

// ===== inc/sfc_pkg.sv
package sfc_pkg;
    // Register byte offsets on the APB port
    localparam logic [7:0] SFC_OFF_FUNC = 8'h00;
    localparam logic [7:0] SFC_OFF_FEAT = 8'h04;
    localparam logic [7:0] SFC_OFF_STATE = 8'h08;
    localparam logic [7:0] SFC_OFF_OPT = 8'h0C;
    localparam logic [7:0] SFC_OFF_GO = 8'h10;
    localparam logic [7:0] SFC_OFF_RESULT = 8'h14;
    localparam logic [7:0] SFC_OFF_WCSTAT = 8'h18;
    localparam logic [7:0] SFC_OFF_INTERVAL = 8'h1C;
    localparam logic [7:0] SFC_OFF_SETFEAT = 8'h20;
    localparam logic [7:0] SFC_OFF_QADDR = 8'h24;
    localparam logic [7:0] SFC_OFF_QDATA = 8'h28;

    // Field positions
    localparam int SFC_GO_BIT = 0;
    localparam int SFC_PERSIST_BIT = 0;
    localparam int SFC_SF_WC_BIT = 0;
    localparam int SFC_WCSTAT_ACT_BIT = 16;
    localparam int SFC_WCSTAT_SF_BIT = 17;
    localparam int SFC_WCSTAT_RO_BIT = 18;
    localparam int SFC_WCSTAT_BUSY_BIT = 31;

    // Function codes
    localparam logic [15:0] SFC_FN_SET = 16'h0001;
    localparam logic [15:0] SFC_FN_GET = 16'h0002;
    localparam logic [15:0] SFC_FN_FLAGS = 16'h0003;

    // Feature codes
    localparam logic [15:0] SFC_FT_WCACHE = 16'h0001;
    localparam logic [15:0] SFC_FT_REORDER = 16'h0002;
    localparam logic [15:0] SFC_FT_INTERVAL = 16'h0003;

    // Feature states
    localparam logic [15:0] SFC_WC_BY_SF = 16'h0001;
    localparam logic [15:0] SFC_WC_FORCE_ON = 16'h0002;
    localparam logic [15:0] SFC_WC_FORCE_OFF = 16'h0003;
    localparam logic [15:0] SFC_RO_EN = 16'h0001;
    localparam logic [15:0] SFC_RO_DIS = 16'h0002;
    localparam logic [15:0] SFC_INTERVAL_BAD = 16'h0000;

    // Reset values
    localparam logic [15:0] SFC_WC_RST = 16'h0001;
    localparam logic [15:0] SFC_INTERVAL_RST = 16'h0001;
    localparam logic SFC_SF_WC_RST = 1'b1;

    // Task-file answers
    localparam logic [7:0] SFC_ERR_OK = 8'h00;
    localparam logic [7:0] SFC_ERR_ABORT = 8'h04;
    localparam logic [7:0] SFC_STAT_OK = 8'h50;
    localparam logic [7:0] SFC_STAT_ERR = 8'h51;

    // History queue
    localparam int SFC_QAW = 7;
    localparam int SFC_QDEPTH = 128;
    localparam logic [6:0] SFC_QLAST = 7'h7F;
    localparam logic [7:0] SFC_QMARK = 8'h80;
endpackage : sfc_pkg

// ===== rtl/sfc_hist_mem.sv
module sfc_hist_mem
    import sfc_pkg::*;
(
    input wire logic pclk,
    input wire logic we,
    input wire logic [SFC_QAW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [SFC_QAW-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:SFC_QDEPTH-1];

    // No reset: contents are defined by the first queue reset
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge pclk) begin
        rdata <= mem[raddr];
    end
endmodule : sfc_hist_mem

// ===== rtl/sfc_wc_policy.sv
module sfc_wc_policy
    import sfc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] policy,
    input wire logic sf_req,
    input wire logic sf_val,
    output logic wc_on,
    output logic sf_wc
);
    logic forced;

    assign forced = (policy != SFC_WC_BY_SF);

    // R8 forced ignores set-features
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sf_wc <= SFC_SF_WC_RST;
        end else if (sf_req && !forced) begin
            sf_wc <= sf_val;
        end
    end

    // R7 forced state wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wc_on <= SFC_SF_WC_RST;
        end else begin
            case (policy)
                SFC_WC_FORCE_ON: wc_on <= 1'b1;
                SFC_WC_FORCE_OFF: wc_on <= 1'b0;
                default: wc_on <= sf_wc;
            endcase
        end
    end

    property p_sf_forced;
        @(posedge pclk) disable iff (!presetn)
        sf_req && forced |=> sf_wc == $past(sf_wc);
    endproperty
    a_sf_forced: assert property (p_sf_forced) else $error("forced cache changed"); // R8
endmodule : sfc_wc_policy

// ===== verif/sfc_host_model.sv
module sfc_host_model (
    input wire logic pclk,
    output logic [7:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0000_0000;
    end

    // One APB transfer; a read toggles pwdata so stale data is never reused
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic err);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : ~pwdata;
        @(posedge pclk);
        penable <= 1'b1;
        // The wait ends once pready is seen high
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
endmodule : sfc_host_model

// ===== verif/sfc_feature_ctrl_tb.sv
module sfc_feature_ctrl_tb
    import sfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hard_reset, log_wr;
    logic wc_enable, id_w85_wc, reorder_en, queue_busy, er;
    logic [7:0] paddr, cur_temp, log_temp;
    logic [31:0] pwdata, prdata, rv;
    logic [15:0] log_interval, m_wc, p_wc, m_int, p_int;
    logic [15:0] m_flg [0:3];
    logic [6:0] queue_index;
    logic [7:0] mq [0:127];
    logic [31:0] rnd = 32'ha6ba_e4a8;
    logic m_sf;
    int error_cnt, total_checks, cyc, m_idx;

    sfc_feature_ctrl sfc_feature_ctrl_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hard_reset(hard_reset), .cur_temp(cur_temp),
        .log_wr(log_wr), .log_temp(log_temp), .wc_enable(wc_enable), .id_w85_wc(id_w85_wc),
        .reorder_en(reorder_en), .log_interval(log_interval), .queue_index(queue_index),
        .queue_busy(queue_busy));

    sfc_host_model sfc_host_model_i (.pclk(pclk), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic wrap_up();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic rd(input logic [7:0] a);
        sfc_host_model_i.xfer(1'b0, a, 32'h0000_0000, rv, er);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        sfc_host_model_i.xfer(1'b1, a, d, rv, er);
    endtask : wr

    // Pins are sampled mid-cycle, clear of the edge updates
    task automatic pins();
        @(negedge pclk);
        chk("wc_enable", {31'h0, m_wc == 2 || (m_wc == 1 && m_sf)}, {31'h0, wc_enable});
        chk("id_w85_wc", {31'h0, wc_enable}, {31'h0, id_w85_wc});
        chk("reorder_en", 32'h0000_0001, {31'h0, reorder_en});
        chk("log_interval", {16'h0, m_int}, {16'h0, log_interval});
        chk("queue_index", m_idx, {25'h0, queue_index});
        @(posedge pclk);
    endtask : pins

    task automatic qchk(input int a);
        wr(SFC_OFF_QADDR, a);
        rd(SFC_OFF_QDATA);
        chk("queue", {24'h0, mq[a]}, rv);
    endtask : qchk

    task automatic log_pulse();
        rnd = lfsr(rnd);
        @(posedge pclk);
        log_wr <= 1'b1;
        log_temp <= rnd[7:0];
        @(posedge pclk);
        log_wr <= 1'b0;
        m_idx = (m_idx + 1) % 128;
        mq[m_idx] = rnd[7:0];
    endtask : log_pulse

    task automatic cmd(input logic [15:0] fn, ft, st, opt);
        logic ok;
        logic [15:0] rs;
        ok = ft inside {[1:3]} && (fn == SFC_FN_SET ? (ft == 1 ? st inside {[1:3]} :
             ft == 2 ? st inside {[1:2]} : st != 0) : fn inside {SFC_FN_GET, SFC_FN_FLAGS});
        rs = 16'h0000;
        if (ok && fn == SFC_FN_SET) begin
            m_flg[ft] = {15'h0, opt[0]};
            if (ft == SFC_FT_WCACHE) m_wc = st;
            if (opt[0] && ft == SFC_FT_WCACHE) p_wc = st;
            if (ft == SFC_FT_INTERVAL) begin
                m_int = st;
                m_idx = 0;
                mq[0] = cur_temp;
                for (int i = 1; i < 128; i++) mq[i] = SFC_QMARK;
            end
            if (opt[0] && ft == SFC_FT_INTERVAL) p_int = st;
        end
        if (ok && fn == SFC_FN_GET) rs = ft == 1 ? m_wc : ft == 2 ? SFC_RO_EN : m_int;
        if (ok && fn == SFC_FN_FLAGS) rs = m_flg[ft];
        wr(SFC_OFF_FUNC, {16'h0, fn});
        wr(SFC_OFF_FEAT, {16'h0, ft});
        wr(SFC_OFF_STATE, {16'h0, st});
        wr(SFC_OFF_OPT, {16'h0, opt});
        wr(SFC_OFF_GO, 32'h0000_0001);
        rd(SFC_OFF_RESULT);
        chk("result", ok ? {rs[15:8], rs[7:0], SFC_STAT_OK, SFC_ERR_OK} :
            {16'h0, SFC_STAT_ERR, SFC_ERR_ABORT}, rv);
        @(negedge pclk);
        chk("queue_busy", {31'h0, ok && fn == SFC_FN_SET && ft == 3}, {31'h0, queue_busy});
        while (queue_busy === 1'b1) @(posedge pclk);
        pins();
    endtask : cmd

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Whole run needs about a thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end

    initial begin
        presetn = 1'b0;
        hard_reset = 1'b0;
        log_wr = 1'b0;
        cur_temp = 8'h00;
        log_temp = 8'h00;
        {m_wc, p_wc, m_int, p_int} = {4{16'h0001}};
        m_flg = '{default: 16'h0000};
        m_sf = 1'b1;
        m_idx = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(SFC_OFF_WCSTAT);
        chk("wcstat", 32'h0007_0001, rv);
        rd(SFC_OFF_INTERVAL);
        chk("interval", 32'h0000_0001, rv);
        rd(SFC_OFF_RESULT);
        chk("result", 32'h0000_5000, rv);
        pins();
        rd(8'h2C);
        chk("pslverr", 32'h0000_0001, {31'h0, er});
        for (int s = 1; s <= 3; s++) begin
            for (int b = 0; b < 2; b++) begin
                cmd(SFC_FN_SET, SFC_FT_WCACHE, s, 16'h0000);
                wr(SFC_OFF_SETFEAT, b);
                if (m_wc == SFC_WC_BY_SF) m_sf = b[0];
                pins();
                rd(SFC_OFF_SETFEAT);
                chk("setfeat", {31'h0, m_sf}, rv);
                cmd(SFC_FN_GET, SFC_FT_WCACHE, 16'h0000, 16'h0000);
            end
        end
        cmd(SFC_FN_SET, SFC_FT_REORDER, SFC_RO_DIS, 16'h0001);
        cmd(SFC_FN_GET, SFC_FT_REORDER, 16'h0000, 16'h0000);
        cmd(SFC_FN_FLAGS, SFC_FT_REORDER, 16'h0000, 16'h0000);
        cmd(SFC_FN_SET, SFC_FT_WCACHE, 16'h0004, 16'h0000);
        cmd(SFC_FN_SET, SFC_FT_REORDER, 16'h0003, 16'h0000);
        cmd(16'h0004, SFC_FT_WCACHE, 16'h0001, 16'h0000);
        cmd(16'h0000, SFC_FT_WCACHE, 16'h0001, 16'h0000);
        cmd(SFC_FN_GET, 16'h0004, 16'h0000, 16'h0000);
        cmd(SFC_FN_FLAGS, 16'hD000, 16'h0000, 16'h0000);
        cmd(SFC_FN_SET, SFC_FT_INTERVAL, SFC_INTERVAL_BAD, 16'h0000);
        for (int k = 0; k < 2; k++) begin
            repeat (3) log_pulse();
            rnd = lfsr(rnd);
            @(posedge pclk);
            cur_temp <= rnd[7:0];
            @(posedge pclk);
            cmd(SFC_FN_SET, SFC_FT_INTERVAL, k == 0 ? 16'hFFFF : rnd[31:16] | 16'h0001, k);
            cmd(SFC_FN_FLAGS, SFC_FT_INTERVAL, 16'h0000, 16'h0000);
            cmd(SFC_FN_GET, SFC_FT_INTERVAL, 16'h0000, 16'h0000);
            qchk(0);
            qchk(3);
            qchk(127);
            log_pulse();
            pins();
            qchk(1);
        end
        cmd(SFC_FN_SET, SFC_FT_WCACHE, SFC_WC_FORCE_ON, 16'h0001);
        cmd(SFC_FN_FLAGS, SFC_FT_WCACHE, 16'h0000, 16'h0000);
        cmd(SFC_FN_SET, SFC_FT_WCACHE, SFC_WC_FORCE_OFF, 16'h0000);
        cmd(SFC_FN_FLAGS, SFC_FT_WCACHE, 16'h0000, 16'h0000);
        @(posedge pclk);
        hard_reset <= 1'b1;
        @(posedge pclk);
        hard_reset <= 1'b0;
        m_wc = p_wc;
        m_int = p_int;
        @(posedge pclk);
        pins();
        cmd(SFC_FN_GET, SFC_FT_WCACHE, 16'h0000, 16'h0000);
        wrap_up();
    end
endmodule : sfc_feature_ctrl_tb
